// file: design/sps_pkg.sv
package sps_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int SPS_NCH        = 2;               // Serial port channels
  localparam int SPS_NPIN       = 2 * SPS_NCH;     // Synchronised pins, sck and sdi per channel
  localparam int SPS_AW         = 12;              // APB address width
  localparam int SPS_DW         = 32;              // APB data width

  // ****************************************************************
  // Register map: printed index, byte address is four times it
  // ****************************************************************
  localparam logic [SPS_NCH-1:0][9:0] SPS_STAT_IDX = {10'h199, 10'h18F};
  localparam logic [9:0] SPS_INT_STAT_IDX = 10'h1A0;
  localparam logic [9:0] SPS_INT_MASK_IDX = 10'h1A1;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int SPS_BIT_PHASE  = 7;               // input_sample_phase
  localparam int SPS_BIT_EDGE   = 6;               // Clock edge / SMBus select
  localparam int SPS_BIT_DATA   = 5;               // Data not address
  localparam int SPS_BIT_STOP   = 4;               // Stop seen last
  localparam int SPS_BIT_START  = 3;               // Start seen last
  localparam int SPS_BIT_RDWR   = 2;               // Read/write of transfer
  localparam int SPS_BIT_ADDR   = 1;               // Address update needed
  localparam int SPS_BIT_FULL   = 0;               // Buffer full
  localparam logic [7:0] SPS_STAT_RESET = 8'h00;
  localparam logic [7:0] SPS_STAT_WMASK = 8'hC0;   // Only bits 7 and 6 are writable

  // ****************************************************************
  // Interrupt events, three per channel
  // ****************************************************************
  localparam int SPS_EVT_START  = 0;
  localparam int SPS_EVT_STOP   = 1;
  localparam int SPS_EVT_BYTE   = 2;
  localparam int SPS_EVT_PER_CH = 3;
  localparam int SPS_NEVT       = SPS_EVT_PER_CH * SPS_NCH;
  localparam logic [SPS_NEVT-1:0] SPS_INT_RESET = 6'h00;
  localparam logic [1:0] SPS_EDGE_ARM = 2'h3;      // Cycles after reset before link edges count

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    SPS_MODE_SPI_MASTER = 4'b0001,
    SPS_MODE_SPI_SLAVE  = 4'b0010,
    SPS_MODE_I2C_MASTER = 4'b0100,
    SPS_MODE_I2C_SLAVE  = 4'b1000
  } sps_mode_e;

  // Bus events and live flags from the rest of the serial port
  typedef struct packed {
    logic start;
    logic stop;
    logic byte_done;
    logic byte_is_data;
    logic rd_wr;
    logic addr_update;
    logic buf_full;
  } sps_evt_s;

  // Link pins of one channel
  typedef struct packed {
    logic sck;
    logic sdi;
  } sps_pins_s;

  // Controls toward the rest of the serial port
  typedef struct packed {
    logic slew_en;
    logic smbus_lvl;
    logic launch;
    logic sample;
    logic rx_bit;
  } sps_ctl_s;

  typedef struct packed {
    logic [7:0] stat;
    sps_ctl_s   ctl;
  } sps_chan_s;

  typedef struct packed {
    sps_chan_s [SPS_NCH-1:0] ch;
    logic [SPS_NEVT-1:0]     int_stat;
    logic [SPS_NEVT-1:0]     int_mask;
    logic [SPS_DW-1:0]       prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
  } sps_state_s;

  typedef struct packed {
    logic [SPS_NPIN-1:0] meta;
    logic [SPS_NPIN-1:0] stab;
  } sps_sync_s;

endpackage

// file: design/sps_sync.sv
`timescale 1ns/100ps
module sps_sync (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [sps_pkg::SPS_NPIN-1:0] d_i,
  output logic      [sps_pkg::SPS_NPIN-1:0] q_o
);
  import sps_pkg::*;

  sps_sync_s s_reg;
  sps_sync_s s_next;

  // Two stages; only the second stage reads the first
  always_comb begin
    s_next      = s_reg;
    s_next.meta = d_i;
    s_next.stab = s_reg.meta;
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stab;

endmodule // sps_sync

// file: design/sps_link_edge.sv
`timescale 1ns/100ps
module sps_link_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sck_i,
  input  wire logic spi_i,
  input  wire logic master_i,
  input  wire logic idle_high_i,
  input  wire logic edge_sel_i,
  input  wire logic phase_end_i,
  output logic      launch_o,
  output logic      sample_o
);
  import sps_pkg::*;

  logic       sck_prev_reg;
  logic       sck_prev_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic       armed;
  logic       to_active;
  logic       to_idle;

  // Edge classification against the idle level
  // Quiet until the synchroniser holds a real pin level, so an idle-high
  // clock gives no false edge after reset
  always_comb begin
    sck_prev_next = sck_i;
    settle_next   = (settle_reg == SPS_EDGE_ARM) ? settle_reg : settle_reg + 2'h1;
    armed         = (settle_reg == SPS_EDGE_ARM);
    to_active     = armed && (sck_prev_reg == idle_high_i) && (sck_i != idle_high_i);
    to_idle       = armed && (sck_prev_reg != idle_high_i) && (sck_i == idle_high_i);
  end

  // Previous serial clock level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_prev_reg <= 1'b0;
      settle_reg   <= 2'h0;
    end else begin
      sck_prev_reg <= sck_prev_next;
      settle_reg   <= settle_next;
    end
  end

  // Launch edge chosen by the edge select bit
  assign launch_o = spi_i & (edge_sel_i ? to_idle : to_active); // R6 R7

  // Sample at the launch edge that ends the bit, or at the edge in its middle
  assign sample_o = spi_i & ((master_i & phase_end_i) ?
                             (edge_sel_i ? to_idle : to_active) :     // R1
                             (edge_sel_i ? to_active : to_idle));     // R2

endmodule // sps_link_edge

// file: design/sps_top.sv
// Behaviour
// R1: SPI master, phase bit set: sample input at the end of output time.
// R2: SPI master, phase bit clear: sample input in the middle of output time.
// R3: Software keeps the phase bit clear while a channel is SPI slave.
// R4: I2C, phase bit set: slew rate control off.
// R5: I2C, phase bit clear: slew rate control on.
// R6: SPI, edge bit set: launch data on active to idle clock transition.
// R7: SPI, edge bit clear: launch data on idle to active clock transition.
// R8: I2C, edge bit set selects SMBus input levels, clear deselects them.
// R9: I2C slave: data flag set after a data byte, cleared after address.
// R10: I2C: stop flag set when stop was the last condition, else clear.
// R11: I2C: start flag set when start was the last condition, else clear.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module sps_top (
  input  wire logic                                      CLK_I,
  input  wire logic                                      SYS_RST_I,
  input  wire logic                                      PSEL_I,
  input  wire logic                                      PENABLE_I,
  input  wire logic                                      PWRITE_I,
  input  wire logic      [sps_pkg::SPS_AW-1:0]           PADDR_I,
  input  wire logic      [sps_pkg::SPS_DW-1:0]           PWDATA_I,
  output logic           [sps_pkg::SPS_DW-1:0]           PRDATA_O,
  output logic                                           PREADY_O,
  output logic                                           PSLVERR_O,
  input  sps_pkg::sps_mode_e [sps_pkg::SPS_NCH-1:0]      MODE_I,
  input  wire logic      [sps_pkg::SPS_NCH-1:0]          CLK_IDLE_HIGH_I,
  input  sps_pkg::sps_evt_s  [sps_pkg::SPS_NCH-1:0]      EVT_I,
  input  sps_pkg::sps_pins_s [sps_pkg::SPS_NCH-1:0]      PINS_I,
  output sps_pkg::sps_ctl_s  [sps_pkg::SPS_NCH-1:0]      CTL_O,
  output logic           [sps_pkg::SPS_NCH-1:0][7:0]     STAT_O,
  output logic                                           IRQ_O
);
  import sps_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sps_state_s          s_reg;
  sps_state_s          s_next;
  logic [SPS_NPIN-1:0] pin_raw;
  logic [SPS_NPIN-1:0] pin_sync;
  logic [SPS_NCH-1:0]  is_spi;
  logic [SPS_NCH-1:0]  is_master;
  logic [SPS_NCH-1:0]  is_i2c;
  logic [SPS_NCH-1:0]  is_i2c_slave;
  logic [SPS_NCH-1:0]  edge_launch;
  logic [SPS_NCH-1:0]  edge_sample;
  logic                setup;
  logic                wr_en;
  logic                hit;
  logic [SPS_NCH-1:0]  sel_stat;
  logic                sel_int_stat;
  logic                sel_int_mask;
  logic [SPS_DW-1:0]   rd_data;
  logic [SPS_NEVT-1:0] int_set;
  logic [SPS_NEVT-1:0] int_clr;
  logic [7:0]          stat;

  // ****************************************************************
  // Link pins and per channel edge finders
  // ****************************************************************

  // Pack pins: sck in the even bit, sdi in the odd bit of each pair
  always_comb begin
    for (int c = 0; c < SPS_NCH; c++) begin
      pin_raw[2*c]   = PINS_I[c].sck;
      pin_raw[2*c+1] = PINS_I[c].sdi;
    end
  end

  sps_sync u_sync (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (pin_raw),
    .q_o   (pin_sync)
  );

  // Mode decode per channel
  always_comb begin
    for (int c = 0; c < SPS_NCH; c++) begin
      is_spi[c]       = (MODE_I[c] == SPS_MODE_SPI_MASTER) ||
                        (MODE_I[c] == SPS_MODE_SPI_SLAVE);
      is_master[c]    = (MODE_I[c] == SPS_MODE_SPI_MASTER);
      is_i2c[c]       = (MODE_I[c] == SPS_MODE_I2C_MASTER) ||
                        (MODE_I[c] == SPS_MODE_I2C_SLAVE);
      is_i2c_slave[c] = (MODE_I[c] == SPS_MODE_I2C_SLAVE);
    end
  end

  // One edge finder per channel, timed by the stored configuration bits
  generate
    for (genvar g = 0; g < SPS_NCH; g++) begin : g_edge
      sps_link_edge u_edge (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .sck_i       (pin_sync[2*g]),
        .spi_i       (is_spi[g]),
        .master_i    (is_master[g]),
        .idle_high_i (CLK_IDLE_HIGH_I[g]),
        .edge_sel_i  (s_reg.ch[g].stat[SPS_BIT_EDGE]),
        .phase_end_i (s_reg.ch[g].stat[SPS_BIT_PHASE]),
        .launch_o    (edge_launch[g]),
        .sample_o    (edge_sample[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Register address decode
  // ****************************************************************

  // One select per register, from the byte address of its index
  always_comb begin
    for (int c = 0; c < SPS_NCH; c++) begin
      sel_stat[c] = (PADDR_I == {SPS_STAT_IDX[c], 2'b00});
    end
    sel_int_stat = (PADDR_I == {SPS_INT_STAT_IDX, 2'b00});
    sel_int_mask = (PADDR_I == {SPS_INT_MASK_IDX, 2'b00});
    hit          = |sel_stat | sel_int_stat | sel_int_mask;
  end

  // Read multiplexer; an unmapped address reads zero
  always_comb begin
    rd_data = '0;
    for (int c = 0; c < SPS_NCH; c++) begin
      if (sel_stat[c]) begin
        rd_data = {24'h00_0000, s_reg.ch[c].stat};
      end
    end
    if (sel_int_stat) begin
      rd_data = {26'h0, s_reg.int_stat};
    end
    if (sel_int_mask) begin
      rd_data = {26'h0, s_reg.int_mask};
    end
  end

  // Transfer phases: setup cycle, and the write strobe at the ready edge
  always_comb begin
    setup = PSEL_I & ~PENABLE_I;
    wr_en = PSEL_I & PENABLE_I & PWRITE_I & s_reg.pready;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_next  = s_reg;
    int_set = '0;
    int_clr = '0;
    stat    = '0;

    // APB answer: ready in the first access cycle, cleared after the handshake
    if (setup) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = ~hit;
      s_next.prdata  = (hit && !PWRITE_I) ? rd_data : '0;
    end else begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
    end

    // Per channel status and controls
    for (int c = 0; c < SPS_NCH; c++) begin
      stat = s_reg.ch[c].stat;

      // Software writes only the two configuration bits
      if (wr_en && sel_stat[c]) begin
        stat = (stat & ~SPS_STAT_WMASK) | (PWDATA_I[7:0] & SPS_STAT_WMASK);
      end

      // Start and stop track the last bus condition; stop wins a tie
      if (is_i2c[c]) begin
        if (EVT_I[c].start) begin
          stat[SPS_BIT_START] = 1'b1;                            // R11
          stat[SPS_BIT_STOP]  = 1'b0;                            // R10
        end
        if (EVT_I[c].stop) begin
          stat[SPS_BIT_STOP]  = 1'b1;                            // R10
          stat[SPS_BIT_START] = 1'b0;                            // R11
        end
      end else begin
        stat[SPS_BIT_STOP]  = 1'b0;                              // Reserved in SPI
        stat[SPS_BIT_START] = 1'b0;
      end

      // Data or address of the last byte, slave only
      if (is_i2c_slave[c]) begin
        if (EVT_I[c].byte_done) begin
          stat[SPS_BIT_DATA] = EVT_I[c].byte_is_data;            // R9
        end
      end else begin
        stat[SPS_BIT_DATA] = 1'b0;                               // Reserved as master
      end

      // Live flags mirrored from the rest of the port
      stat[SPS_BIT_RDWR] = EVT_I[c].rd_wr;
      stat[SPS_BIT_ADDR] = EVT_I[c].addr_update;
      stat[SPS_BIT_FULL] = EVT_I[c].buf_full;
      s_next.ch[c].stat  = stat;

      // I2C pad controls from the configuration bits
      s_next.ch[c].ctl.slew_en   = is_i2c[c] & ~s_reg.ch[c].stat[SPS_BIT_PHASE]; // R4 R5
      s_next.ch[c].ctl.smbus_lvl = is_i2c[c] & s_reg.ch[c].stat[SPS_BIT_EDGE];   // R8

      // SPI strobes and the bit caught at the sample edge
      s_next.ch[c].ctl.launch = edge_launch[c];                  // R6 R7
      s_next.ch[c].ctl.sample = edge_sample[c];                  // R1 R2
      if (edge_sample[c]) begin
        s_next.ch[c].ctl.rx_bit = pin_sync[2*c+1];               // R1 R2
      end

      // Bus events raise interrupt flags
      int_set[SPS_EVT_PER_CH*c+SPS_EVT_START] = is_i2c[c] & EVT_I[c].start;
      int_set[SPS_EVT_PER_CH*c+SPS_EVT_STOP]  = is_i2c[c] & EVT_I[c].stop;
      int_set[SPS_EVT_PER_CH*c+SPS_EVT_BYTE]  = is_i2c[c] & EVT_I[c].byte_done;
    end

    // Interrupt status: write one to clear, a new event wins over the clear
    if (wr_en && sel_int_stat) begin
      int_clr = PWDATA_I[SPS_NEVT-1:0];
    end
    s_next.int_stat = (s_reg.int_stat & ~int_clr) | int_set;
    if (wr_en && sel_int_mask) begin
      s_next.int_mask = PWDATA_I[SPS_NEVT-1:0];
    end
    s_next.irq = |(s_next.int_stat & s_next.int_mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_reg          <= '0;
      s_reg.int_stat <= SPS_INT_RESET;
      s_reg.int_mask <= SPS_INT_RESET;
      for (int c = 0; c < SPS_NCH; c++) begin
        s_reg.ch[c].stat <= SPS_STAT_RESET;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < SPS_NCH; c++) begin
      CTL_O[c]  = s_reg.ch[c].ctl;
      STAT_O[c] = s_reg.ch[c].stat;
    end
  end

  assign PRDATA_O  = s_reg.prdata;
  assign PREADY_O  = s_reg.pready;
  assign PSLVERR_O = s_reg.pslverr;
  assign IRQ_O     = s_reg.irq;

endmodule // sps_top

// file: tb/sps_link_model.sv
`timescale 1ns/100ps
// ********************
// Far-side SPI device
// ********************
module sps_link_model (
  output logic sck_o,
  output logic sdi_o
);
  // Clock idles low and stands still between frames
  initial begin
    sck_o = 1'h0;
    sdi_o = 1'h0;
  end
  // One byte, msb first, 320 ns per bit, data changes mid-low
  task automatic frame(input logic [7:0] d);
    #7;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = d[i];
      #80 sck_o = 1'h1;
      #160 sck_o = 1'h0;
      #80;
    end
    sdi_o = ~d[0]; // Released line shows no stale bit
  endtask
endmodule // sps_link_model

// file: tb/sps_assertions.sv
`timescale 1ns/100ps
module sps_assertions import sps_pkg::*; (
  input  wire logic                     CLK_I,
  input  wire logic                     SYS_RST_I,
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PREADY_O,
  input  wire logic [SPS_NCH-1:0]       CLK_IDLE_HIGH_I,
  input  sps_mode_e [SPS_NCH-1:0]       MODE_I,
  input  sps_evt_s  [SPS_NCH-1:0]       EVT_I,
  input  sps_pins_s [SPS_NCH-1:0]       PINS_I,
  input  sps_ctl_s  [SPS_NCH-1:0]       CTL_O,
  input  wire logic [SPS_NCH-1:0][7:0]  STAT_O
);
  // ********************
  // Helpers
  // ********************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [1:0] up_reg;
  logic       i2c0;
  logic       spi0;
  logic       spi1;
  // Mode decode
  assign i2c0 = MODE_I[0][2] | MODE_I[0][3];
  assign spi0 = MODE_I[0][0] | MODE_I[0][1];
  assign spi1 = MODE_I[1][0] | MODE_I[1][1];
  // Settle count after reset release
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  slew_ctl_a: assert property (up_reg == 2'h3 && $stable(MODE_I[0]) && $stable(STAT_O[0])
    |-> CTL_O[0].slew_en == (i2c0 && !STAT_O[0][7])) else $error("slew enable wrong");
  smbus_sel_a: assert property (up_reg == 2'h3 && $stable(MODE_I[0]) && $stable(STAT_O[0])
    |-> CTL_O[0].smbus_lvl == (i2c0 && STAT_O[0][6])) else $error("smbus level wrong");
  launch_rise_a: assert property (spi0 && !STAT_O[0][6]
    && $rose(PINS_I[0].sck ^ CLK_IDLE_HIGH_I[0]) |-> ##[2:6] CTL_O[0].launch)
    else $error("no launch on leading edge");
  launch_fall_a: assert property (spi1 && STAT_O[1][6]
    && $fell(PINS_I[1].sck ^ CLK_IDLE_HIGH_I[1]) |-> ##[2:6] CTL_O[1].launch)
    else $error("no launch on trailing edge");
  sample_end_a: assert property (MODE_I[0] == SPS_MODE_SPI_MASTER && STAT_O[0][7]
    && CTL_O[0].launch |-> CTL_O[0].sample) else $error("late sample missing");
  sample_mid_a: assert property (MODE_I[1] == SPS_MODE_SPI_MASTER && !STAT_O[1][7]
    && CTL_O[1].launch |-> !CTL_O[1].sample) else $error("middle sample wrong");
  start_flag_a: assert property (i2c0 && EVT_I[0].start && !EVT_I[0].stop
    |=> STAT_O[0][4:3] == 2'h1) else $error("start flag wrong");
  stop_flag_a: assert property (i2c0 && EVT_I[0].stop
    |=> STAT_O[0][4:3] == 2'h2) else $error("stop flag wrong");
  data_flag_a: assert property (MODE_I[0] == SPS_MODE_I2C_SLAVE && EVT_I[0].byte_done
    |=> STAT_O[0][5] == $past(EVT_I[0].byte_is_data)) else $error("data flag wrong");
  ready_pulse_a: assert property (PSEL_I && !PENABLE_I
    |=> PREADY_O ##1 !PREADY_O) else $error("ready not one cycle");
endmodule // sps_assertions

bind sps_top sps_assertions i_sps_assertions (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .MODE_I(MODE_I),
  .CLK_IDLE_HIGH_I(CLK_IDLE_HIGH_I),
  .EVT_I(EVT_I), .PINS_I(PINS_I), .CTL_O(CTL_O), .STAT_O(STAT_O));

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sps_pkg::*;
  logic                    clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [SPS_AW-1:0]       paddr;
  logic [SPS_DW-1:0]       pwdata, prdata, rdat;
  sps_mode_e [1:0]         mode;
  sps_evt_s  [1:0]         evt;
  sps_pins_s [1:0]         pins;
  sps_ctl_s  [1:0]         ctl;
  logic [1:0][7:0]         stat;
  wire  [1:0]              sck, sdi;
  logic [1:0]              idle;
  int                      miscompares, n_compared;
  int                      n_launch [2];
  int                      n_sample [2];
  // ********************
  // Clock, design, partners
  // ********************
  initial clk = 1'h0;
  always #20 clk = ~clk;
  sps_top i_sps_top (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MODE_I(mode), .CLK_IDLE_HIGH_I(idle),
    .EVT_I(evt), .PINS_I(pins), .CTL_O(ctl), .STAT_O(stat), .IRQ_O(irq));
  for (genvar c = 0; c < 2; c++) begin : g_link
    sps_link_model i_sps_link_model (.sck_o(sck[c]), .sdi_o(sdi[c]));
  end
  // Pins seen by the block; an idle-high channel sees the model clock inverted
  assign pins = {sck[1] ^ idle[1], sdi[1], sck[0] ^ idle[0], sdi[0]};
  // Pulse counters on the link controls
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (ctl[c].launch === 1'h1) n_launch[c]++;
      if (ctl[c].sample === 1'h1) n_sample[c]++;
    end
  end
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer: hold until pready sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic pulse(input int k, input logic dat);
    @(posedge clk);
    evt[0].start <= (k == 0); evt[0].stop <= (k == 1); evt[0].byte_done <= (k == 2);
    evt[0].byte_is_data <= dat;
    @(posedge clk);
    evt[0] <= '0;
  endtask
  task automatic frames(input logic [7:0] d0, input logic [7:0] d1);
    repeat (4) @(posedge clk);
    n_launch = '{0, 0}; n_sample = '{0, 0};
    fork
      g_link[0].i_sps_link_model.frame(d0);
      g_link[1].i_sps_link_model.frame(d1);
    join
    repeat (8) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #1_000_000;
    miscompares++;
    complete_run();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    logic [9:0] idx [4];
    logic [11:0] s0, s1, is, im;
    idx = '{SPS_STAT_IDX[0], SPS_STAT_IDX[1], SPS_INT_STAT_IDX, SPS_INT_MASK_IDX};
    s0 = ad(SPS_STAT_IDX[0]); s1 = ad(SPS_STAT_IDX[1]);
    is = ad(SPS_INT_STAT_IDX); im = ad(SPS_INT_MASK_IDX);
    rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = '0;
    evt = '0;
    idle = 2'h0;
    mode[0] = SPS_MODE_SPI_MASTER;
    mode[1] = SPS_MODE_SPI_MASTER;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    foreach (idx[i]) rd(ad(idx[i]), 32'h0);
    apb(1'h1, s0, 32'hFFFF_FFFF);
    rd(s0, 32'h0000_00C0);
    rd(12'hFF0, 32'h0);
    chk(err, 32'h1);
    $display("test registers done");
    apb(1'h1, s0, 32'h80);
    apb(1'h1, s1, 32'h40);
    frames(8'hA5, 8'h3C);
    chk(n_launch[0], 32'h8);
    chk(n_launch[1], 32'h8);
    chk(n_sample[0], 32'h8);
    chk(n_sample[1], 32'h8);
    chk(ctl[0].rx_bit, 32'h1);
    chk(ctl[1].rx_bit, 32'h0);
    mode[1] <= SPS_MODE_SPI_SLAVE;
    idle[1] <= 1'h1;
    apb(1'h1, s1, 32'h40);
    frames(8'h5A, 8'h81);
    chk(n_launch[1], 32'h8);
    chk(n_sample[1], 32'h8);
    chk(ctl[1].rx_bit, 32'h1);
    chk(ctl[0].rx_bit, 32'h0);
    $display("test spi link done");
    mode[0] <= SPS_MODE_I2C_MASTER;
    apb(1'h1, s0, 32'h0);
    repeat (3) @(posedge clk);
    chk(ctl[0].slew_en, 32'h1);
    chk(ctl[0].smbus_lvl, 32'h0);
    apb(1'h1, s0, 32'hC0);
    repeat (3) @(posedge clk);
    chk(ctl[0].slew_en, 32'h0);
    chk(ctl[0].smbus_lvl, 32'h1);
    $display("test i2c levels done");
    mode[0] <= SPS_MODE_I2C_SLAVE;
    apb(1'h1, im, 32'h3F);
    apb(1'h1, s0, 32'h0);
    pulse(0, 1'h0);
    rd(s0, 32'h08);
    chk(irq, 32'h1);
    pulse(2, 1'h1);
    rd(s0, 32'h28);
    pulse(1, 1'h0);
    rd(s0, 32'h30);
    pulse(2, 1'h0);
    rd(s0, 32'h10);
    rd(is, 32'h07);
    apb(1'h1, im, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    apb(1'h1, is, 32'h07);
    rd(is, 32'h0);
    $display("test events done");
    n_launch = '{0, 0};
    n_sample = '{0, 0};
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (8) @(posedge clk);
    chk(n_sample[1], 32'h0);
    chk(n_launch[1], 32'h0);
    rd(s1, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule // tb_top
